// ### page_translation_protect_check_test.sv
// page_translation_protect_check_test: self-checking bench for ptpc_top.
// assumes: package, table, top, checker and core model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module page_translation_protect_check_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        go = 1'b0;
  logic [15:0] va = 16'h0000;
  logic [1:0]  ty = 2'h0;
  logic        pc = 1'b0;
  logic [3:0]  lv = 4'h0;
  logic        acc_valid, pc_rel, pa_valid, grant, irq;
  logic [15:0] vaddr;
  logic [1:0]  acc_type;
  logic [3:0]  level, irq_lvl, irq_code;
  logic [23:0] paddr;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic        wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [31:0] ent [256];
  logic [5:0]  ctl [16];
  logic [1:0]  st;
  logic [19:0] flt = 20'h0; // shadow of the last fault: code and address
  logic [28:0] aq [$];
  logic [31:0] rq [$];
  logic [31:0] seed = 32'h44; // xorshift starts at 68
  int          fail_count = 0, check_count = 0;
  always #10 clk = ~clk;
  ptpc_core_model u_core (.clk(clk), .go(go), .va(va), .ty(ty), .pc(pc), .lv(lv),
    .acc_valid(acc_valid), .vaddr(vaddr), .acc_type(acc_type), .pc_rel(pc_rel), .level(level));
  ptpc_top u_dut (.CLK(clk), .RST_N(rst_n), .ACC_VALID(acc_valid), .VADDR(vaddr),
    .ACC_TYPE(acc_type), .PC_REL(pc_rel), .LEVEL(level), .PA_VALID(pa_valid), .PADDR(paddr),
    .ACC_GRANT(grant), .IRQ(irq), .IRQ_LVL(irq_lvl), .IRQ_CODE(irq_code), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // register write; the shadow tables follow every mapped write
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    if (a < 12'h100) ent[a[7:0]] = d;
    else if (a < 12'h110) ctl[a[3:0]] = d[5:0];
    else if (a == 12'h110) st = d[1:0];
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    if (a < 12'h100) rq.push_back(ent[a[7:0]]);
    else if (a < 12'h110) rq.push_back({26'h0, ctl[a[3:0]]});
    else if (a == 12'h110) rq.push_back({30'h0, st});
    else if (a == 12'h111) rq.push_back({12'h0, flt});
    else rq.push_back(32'h0);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // one access; go stays high so calls in a row run back to back
  task automatic acc(input logic [3:0] l, input logic [15:0] v, input logic [1:0] t,
                     input logic p);
    logic [5:0]  c;
    logic [7:0]  i;
    logic [31:0] e;
    logic        ok;
    c = ctl[l];
    i = {(p || !st[0]) ? c[5:4] : c[3:2], v[15:10]};
    e = ent[i];
    ok = (t == 2'h0) ? e[30] : (t == 2'h1) ? e[31] : (t == 2'h2) ? e[29] : e[30] | e[29];
    ok = ok && (e[26:25] <= c[1:0]);
    aq.push_back({ok, e[31:29] == 3'h0 ? 4'h3 : 4'h2, st[1] ? e[13:0] : {5'h00, e[8:0]},
                  v[9:0]});
    if (!ok) flt = {e[31:29] == 3'h0 ? 4'h3 : 4'h2, v};
    if (ok) ent[i][27] = 1'b1;
    if (ok && t == 2'h1) ent[i][28] = 1'b1;
    if (ok && t == 2'h2 && c[1:0] == 2'h3) ctl[l][1:0] = e[26:25];
    lv <= l;
    va <= v;
    ty <= t;
    pc <= p;
    go <= 1'b1;
    @(posedge clk);
  endtask
  // idle long enough for usage marks to land before the next register access
  task automatic idle(input int n);
    go <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp_acc();
    logic [28:0] x;
    check_count++;
    if (aq.size() == 0) begin
      fail_count++;
      $display("BAD answer exp none got %b%b", grant, irq);
    end else begin
      x = aq.pop_front();
      if (grant !== x[28] || irq !== !x[28] || (grant && paddr !== x[23:0]) ||
          (irq && (irq_code !== x[27:24] || irq_lvl !== ptpc_pkg::IRQ_LEVEL))) begin
        fail_count++;
        $display("BAD answer exp %h got %b%b %h %h", x, grant, irq, irq_code, paddr);
      end
    end
  endtask
  task automatic cmp_rd();
    logic [31:0] x;
    x = rq.pop_front();
    check_count++;
    if (rdata !== x) begin
      fail_count++;
      $display("BAD rdata exp %h got %h", x, rdata);
    end
  endtask
  // watcher: answers and read data are settled at the falling edge
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (pa_valid === 1'b1) cmp_acc();
    if (rd_seen) cmp_rd();
  end
  task automatic stop_test();
    if (aq.size() != 0 || rq.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 256; k++) ent[k] = 32'h0;
    for (int k = 0; k < 16; k++) ctl[k] = 6'h00;
    st = 2'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset contents, an unmapped place, an absent page
    rd_reg(12'h0c5);
    rd_reg(12'h107);
    rd_reg(12'h110);
    rd_reg(12'h3f0);
    acc(4'h0, 16'h0405, 2'h0, 1'b0);
    idle(2);
    rd_reg(12'h111);
    // every permission mix against every access kind, in both address modes
    for (int m = 0; m < 2; m++) begin
      wr_reg(12'h110, {30'h0, m[0], 1'b0});
      for (int p = 0; p < 8; p++) begin
        r = xs();
        wr_reg(12'h002, {p[2:0], 15'h0, r[13:0]});
        for (int t = 0; t < 4; t++) acc(4'h0, {6'h02, r[25:16]}, t[1:0], 1'b0);
        idle(2);
        rd_reg(12'h002);
      end
    end
    // user ring against page ring, each of 16 pairs on a level of its own, then an absent page on level 0
    for (int k = 0; k < 17; k++) begin
      r = xs();
      wr_reg({8'h10, k[3:0]}, {30'h0, k[1:0]});
      wr_reg(12'h003, {k[4] ? 3'h0 : 3'h7, 2'h0, k[4] ? 2'h3 : k[3:2], 11'h0, r[13:0]});
      acc(k[3:0], {6'h03, r[29:20]}, r[31:30], 1'b0);
      idle(2);
    end
    // primary against alternate table selection
    wr_reg(12'h101, 32'h0000_001b);
    wr_reg(12'h044, 32'he000_1111);
    wr_reg(12'h084, 32'he000_2222);
    for (int m = 0; m < 4; m++) begin
      r = xs();
      wr_reg(12'h110, {30'h0, 1'b1, m[1]});
      acc(4'h1, {6'h04, r[9:0]}, 2'h0, m[0]);
      idle(2);
    end
    // ring-3 data access keeps the ring, a fetch from ring 1 drops it
    wr_reg(12'h102, 32'h0000_0003);
    wr_reg(12'h005, 32'he200_0123);
    wr_reg(12'h006, 32'he400_0456);
    acc(4'h2, 16'h1400, 2'h0, 1'b0);
    idle(2);
    rd_reg(12'h102);
    acc(4'h2, 16'h1401, 2'h2, 1'b0);
    acc(4'h2, 16'h1802, 2'h0, 1'b0);
    idle(2);
    rd_reg(12'h102);
    rd_reg(12'h111);
    stop_test();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// ### ptpc_chk_asserts.sv
// ptpc_chk_asserts: port-level assertions for ptpc_top.
// assumes: bound to every ptpc_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ptpc_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // access port
  input wire logic        ACC_VALID,
  input wire logic [15:0] VADDR,
  input wire logic        PA_VALID,
  input wire logic [23:0] PADDR,
  input wire logic        ACC_GRANT,
  input wire logic        IRQ,
  input wire logic [3:0]  IRQ_LVL,
  input wire logic [3:0]  IRQ_CODE,
  // register port
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic ext;
  logic st_wr;
  // shadow of the extended-mode bit; a same-edge status write is left out
  assign st_wr = REG_WR && REG_ADDR == 12'h110;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ext <= 1'b0;
    else if (st_wr) ext <= REG_WDATA[1];
  end
  property p_answer; ACC_VALID |=> PA_VALID; endproperty
  a_answer: assert property (p_answer)
    else $error("access got no answer");
  property p_quiet; !ACC_VALID |=> !(PA_VALID || ACC_GRANT || IRQ); endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without access");
  property p_one; PA_VALID |-> (ACC_GRANT ^ IRQ); endproperty
  a_one: assert property (p_one)
    else $error("grant and fault not exclusive");
  property p_irq_ans; IRQ |-> PA_VALID && $past(ACC_VALID); endproperty
  a_irq_ans: assert property (p_irq_ans)
    else $error("fault outside an answer");
  property p_lvl; IRQ |-> IRQ_LVL == 4'he; endproperty
  a_lvl: assert property (p_lvl)
    else $error("fault level wrong");
  property p_code; IRQ |-> IRQ_CODE == 4'h2 || IRQ_CODE == 4'h3; endproperty
  a_code: assert property (p_code)
    else $error("fault code out of set");
  property p_ofs; ACC_VALID |=> PADDR[9:0] == $past(VADDR[9:0]); endproperty
  a_ofs: assert property (p_ofs)
    else $error("page offset altered");
  property p_norm; ACC_VALID && !ext && !st_wr |=> PADDR[23:19] == 5'h00; endproperty
  a_norm: assert property (p_norm)
    else $error("normal mode high frame bits set");
  c_grant: cover property (PA_VALID && ACC_GRANT);
  c_prot: cover property (IRQ && IRQ_CODE == 4'h2);
  c_abs: cover property (IRQ && IRQ_CODE == 4'h3);
endmodule
bind ptpc_top ptpc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ACC_VALID(ACC_VALID),
  .VADDR(VADDR), .PA_VALID(PA_VALID), .PADDR(PADDR), .ACC_GRANT(ACC_GRANT),
  .IRQ(IRQ), .IRQ_LVL(IRQ_LVL), .IRQ_CODE(IRQ_CODE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR));
`default_nettype wire

// ### ptpc_core_model.sv
// ptpc_core_model: processor side that launches one access per cycle.
// assumes: the bench hands it a request on go; idle lines do not hold old values.
`timescale 1ns/1ps
`default_nettype none
module ptpc_core_model (
  // clock
  input wire logic        clk,
  // request from the bench
  input wire logic        go,
  input wire logic [15:0] va,
  input wire logic [1:0]  ty,
  input wire logic        pc,
  input wire logic [3:0]  lv,
  // access port of the block
  output logic            acc_valid,
  output logic [15:0]     vaddr,
  output logic [1:0]      acc_type,
  output logic            pc_rel,
  output logic [3:0]      level
);
  // known values at time zero
  initial begin
    acc_valid = 1'b0;
    vaddr = 16'h0000;
    acc_type = 2'h0;
    pc_rel = 1'b0;
    level = 4'h0;
  end
  // launch on the edge; between accesses the lines invert every cycle, so stale data comes back on every second idle cycle
  always @(posedge clk) begin
    acc_valid <= go;
    vaddr <= go ? va : ~vaddr;
    acc_type <= go ? ty : ~acc_type;
    pc_rel <= go ? pc : ~pc_rel;
    level <= go ? lv : ~level;
  end
endmodule
`default_nettype wire

// ### ptpc_pkg.sv
// ptpc_pkg: constants and types for the page translation and protection checker.
// assumes: used by ptpc_top and ptpc_table; every use is qualified with ptpc_pkg::.
package ptpc_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int VA_W      = 16;
  localparam int VPN_W     = 6;
  localparam int OFS_W     = 10;
  localparam int FRAME_W   = 14;
  localparam int PA_W      = 24;
  localparam int NORM_ZERO = 5;
  localparam int LEVELS    = 16;
  localparam int TABLES    = 4;
  // ---------------------------------------------------------------
  // entry fields (bit positions in the 32-bit entry, protect half high)
  // ---------------------------------------------------------------
  localparam int E_WRITE   = 31;   // protect bit 15
  localparam int E_READ    = 30;   // protect bit 14
  localparam int E_FETCH   = 29;   // protect bit 13
  localparam int E_DIRTY   = 28;   // protect bit 12
  localparam int E_TOUCH   = 27;   // protect bit 11
  localparam int E_RING_HI = 26;   // protect bit 10
  localparam int E_RING_LO = 25;   // protect bit 9
  localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // level paging control: bits 5:4 table, 3:2 alt table, 1:0 ring
  // ---------------------------------------------------------------
  localparam int C_PT_LO   = 4;
  localparam int C_APT_LO  = 2;
  localparam int C_RING_LO = 0;
  localparam logic [5:0] CTRL_RST  = 6'h00;
  // ---------------------------------------------------------------
  // register port offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_ENTRY  = 12'h000; // 0x000..0x0ff: table*64+vpn
  localparam logic [11:0] OFS_CTRL   = 12'h100; // 0x100..0x10f: level
  localparam logic [11:0] OFS_STATUS = 12'h110; // bit0 table mode, bit1 extended
  localparam logic [11:0] OFS_FAULT  = 12'h111; // last fault
  localparam int ST_TMODE = 0;
  localparam int ST_EXT   = 1;
  // ---------------------------------------------------------------
  // access types and interrupt codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_LOAD  = 2'h0,
    ACC_STORE = 2'h1,
    ACC_FETCH = 2'h2,
    ACC_IND   = 2'h3
  } ptpc_acc_t;
  localparam logic [3:0] IRQ_LEVEL         = 4'he;
  localparam logic [3:0] PROTECT_VIOL_CODE = 4'h2;
  localparam logic [3:0] MISSING_PAGE_CODE = 4'h3;
endpackage

// ### ptpc_table.sv
// ptpc_table: four page tables of 64 entries held in flip-flops.
// assumes: lookup index stable during the access cycle; software writes are rare.
`timescale 1ns/1ps
`default_nettype none
module ptpc_table #(
  parameter int ENTRIES = 256
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // owner side
  ptpc_table_if.store     tbl
);
  logic [31:0] mem [ENTRIES];

  // combinational reads so the check fits in the same cycle
  assign tbl.rd_entry = mem[tbl.rd_idx];
  assign tbl.sw_rdata = mem[tbl.sw_idx];

  // -------------------------------------------------------------
  // storage; usage marks win over a software write of the same entry
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= ptpc_pkg::ENTRY_RST;
        end else begin
          if (tbl.sw_we && tbl.sw_idx == 8'(g)) begin
            mem[g] <= tbl.sw_wdata;
          end
          if (tbl.mark && tbl.rd_idx == 8'(g)) begin
            mem[g][ptpc_pkg::E_TOUCH] <= 1'b1;
            if (tbl.mark_dirty) begin
              mem[g][ptpc_pkg::E_DIRTY] <= 1'b1;
            end
            if (tbl.sw_we && tbl.sw_idx == 8'(g)) begin
              mem[g] <= tbl.sw_wdata
                        | (32'h1 << ptpc_pkg::E_TOUCH)
                        | ({31'h0, tbl.mark_dirty} << ptpc_pkg::E_DIRTY);
            end
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### ptpc_table_if.sv
// ptpc_table_if: page table lookup and write-back signals between top and table.
// assumes: single clock, driven by ptpc_top.
`timescale 1ns/1ps
`default_nettype none
interface ptpc_table_if;
  logic [7:0]  rd_idx;    // table*64 + vpn for lookup
  logic [31:0] rd_entry;  // combinational entry
  logic [7:0]  sw_idx;    // software access index
  logic [31:0] sw_wdata;
  logic        sw_we;
  logic [31:0] sw_rdata;
  logic        mark;      // set usage bits at rd_idx
  logic        mark_dirty;
  modport owner (output rd_idx, sw_idx, sw_wdata, sw_we, mark, mark_dirty,
                 input rd_entry, sw_rdata);
  modport store (input rd_idx, sw_idx, sw_wdata, sw_we, mark, mark_dirty,
                 output rd_entry, sw_rdata);
endinterface
`default_nettype wire

// ### ptpc_top.sv
// ptpc_top: translation and protection check for one paged access per cycle.
// assumes: the processor presents one access per cycle with ACC_VALID and takes
// the answer in the next cycle; registers reached over a plain strobe port.
// limitation: one translation per cycle with no table cache; a denied store or
// fetch is only flagged here, the core itself must drop the write or execution.
`timescale 1ns/1ps
`default_nettype none
module ptpc_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // access request from address arithmetic
  input  wire logic        ACC_VALID,
  input  wire logic [15:0] VADDR,
  input  wire logic [1:0]  ACC_TYPE,
  input  wire logic        PC_REL,
  input  wire logic [3:0]  LEVEL,
  // translation answer
  output logic             PA_VALID,
  output logic [23:0]      PADDR,
  output logic             ACC_GRANT,
  output logic             IRQ,
  output logic [3:0]       IRQ_LVL,
  output logic [3:0]       IRQ_CODE,
  // register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  // entry into reset is immediate, the exit waits two edges to meet the clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  // table storage lives in its own module, reached through the carrier
  ptpc_table_if tif ();
  // one control word per program level
  logic [5:0]  ctrl [ptpc_pkg::LEVELS];
  logic        table_mode_flag;
  logic        ext_mode;
  logic [3:0]  fault_code;
  logic [15:0] fault_vaddr;

  ptpc_table #(
    .ENTRIES (ptpc_pkg::TABLES * 64)
  ) u_table (
    .clk   (CLK),
    .rst_n (rst_n),
    .tbl   (tif.store)
  );

  // ring field of a level control word; used by check and update paths
  function automatic logic [1:0] ring_of(input logic [5:0] c);
    ring_of = c[ptpc_pkg::C_RING_LO +: 2];
  endfunction

  // software address inside the entry window; shared by write and read decode
  function automatic logic in_entry_win(input logic [11:0] a);
    in_entry_win = a[11:8] == ptpc_pkg::OFS_ENTRY[11:8];
  endfunction

  // one interrupt code per faulting access: an absent page hides any other cause
  function automatic logic [3:0] fault_of(input logic absent_page);
    fault_of = absent_page ? ptpc_pkg::MISSING_PAGE_CODE
                           : ptpc_pkg::PROTECT_VIOL_CODE;
  endfunction

  // -------------------------------------------------------------
  // table selection and lookup
  // -------------------------------------------------------------
  logic [5:0]  cur_ctrl;
  logic        use_alt;
  logic [1:0]  tsel;
  logic [5:0]  virtual_page_number;
  logic [9:0]  page_offset;
  logic [31:0] entry;

  // the running level picks its control word and with it the user ring
  assign cur_ctrl            = ctrl[LEVEL];
  assign use_alt             = table_mode_flag && !PC_REL;
  assign tsel                = use_alt ? cur_ctrl[ptpc_pkg::C_APT_LO +: 2]
                                       : cur_ctrl[ptpc_pkg::C_PT_LO +: 2];
  // 1K-word pages: the offset bits pass through untouched
  assign virtual_page_number = VADDR[15:10];
  assign page_offset         = VADDR[9:0];
  assign tif.rd_idx          = {tsel, virtual_page_number};
  assign entry               = tif.rd_entry;

  // -------------------------------------------------------------
  // permission and ring checks, evaluated independently
  // -------------------------------------------------------------
  logic        write_allow;
  logic        read_allow;
  logic        fetch_allow;
  logic [1:0]  page_ring;
  logic [1:0]  user_ring;
  logic        absent;
  logic        perm_ok;
  logic        ring_ok;
  logic        next_ok;
  logic [13:0] physical_frame_number;

  // protect half of the entry, same layout in both address modes
  assign write_allow = entry[ptpc_pkg::E_WRITE];
  assign read_allow  = entry[ptpc_pkg::E_READ];
  assign fetch_allow = entry[ptpc_pkg::E_FETCH];
  assign page_ring   = entry[ptpc_pkg::E_RING_HI:ptpc_pkg::E_RING_LO];
  assign user_ring   = ring_of(cur_ctrl);
  assign absent      = !write_allow && !read_allow && !fetch_allow;

  // an indirect word may come from a code page or from a data page
  always_comb begin
    case (ACC_TYPE)
      ptpc_pkg::ACC_STORE: perm_ok = write_allow;
      ptpc_pkg::ACC_LOAD:  perm_ok = read_allow;
      ptpc_pkg::ACC_FETCH: perm_ok = fetch_allow;
      ptpc_pkg::ACC_IND:   perm_ok = fetch_allow || read_allow;
      default:             perm_ok = 1'b0;
    endcase
  end

  // ring 3 may fetch from any ring (and is lowered), otherwise page ring <= user
  assign ring_ok = (page_ring <= user_ring);
  assign next_ok = perm_ok && ring_ok && !absent;

  // a valid access ends in exactly one of grant or fault
  logic granted;
  logic faulted;
  assign granted = ACC_VALID && next_ok;
  assign faulted = ACC_VALID && !next_ok;

  // frame number, top bits cleared in 19-bit mode
  // the result is a 24-bit word address in extended mode, 19-bit in normal mode
  assign physical_frame_number = ext_mode ? entry[13:0]
                               : {5'h00, entry[8:0]};

  // -------------------------------------------------------------
  // usage marks
  // -------------------------------------------------------------
  // only granted accesses mark, so a blocked store leaves no trace; the table
  // ORs a mark into a same-cycle software write of the entry, so none is lost
  assign tif.mark       = granted;
  assign tif.mark_dirty = ACC_TYPE == ptpc_pkg::ACC_STORE;

  // -------------------------------------------------------------
  // answer, registered one cycle after the request
  // -------------------------------------------------------------
  // PADDR follows every cycle and means something only beside PA_VALID
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PA_VALID  <= 1'b0;
      PADDR     <= 24'h000000;
      ACC_GRANT <= 1'b0;
    end else begin
      PA_VALID  <= ACC_VALID;
      ACC_GRANT <= granted;
      PADDR     <= {physical_frame_number, page_offset};
    end
  end

  // -------------------------------------------------------------
  // fault report
  // -------------------------------------------------------------
  // absent page first, then permission or ring violation
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ      <= 1'b0;
      IRQ_LVL  <= 4'h0;
      IRQ_CODE <= 4'h0;
    end else begin
      IRQ      <= faulted;
      IRQ_LVL  <= ptpc_pkg::IRQ_LEVEL;
      IRQ_CODE <= fault_of(absent);
    end
  end

  // -------------------------------------------------------------
  // last fault capture
  // -------------------------------------------------------------
  // only the newest fault is kept; software reads it before the next one lands
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fault_code  <= 4'h0;
      fault_vaddr <= 16'h0000;
    end else if (faulted) begin
      fault_code  <= fault_of(absent);
      fault_vaddr <= VADDR;
    end
  end

  // -------------------------------------------------------------
  // level control words; hardware ring lowering wins over a write
  // -------------------------------------------------------------
  // only a granted instruction fetch degrades the user; data never does
  logic ring3_user;
  logic low_page;
  logic lower;
  assign ring3_user = user_ring == 2'h3;
  assign low_page   = page_ring != 2'h3;
  assign lower      = granted && ACC_TYPE == ptpc_pkg::ACC_FETCH
                      && ring3_user && low_page;

  // one process per level keeps every control word on a single driver
  genvar l;
  generate
    for (l = 0; l < ptpc_pkg::LEVELS; l++) begin : g_lvl
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          ctrl[l] <= ptpc_pkg::CTRL_RST;
        end else begin
          if (REG_WR && REG_ADDR == ptpc_pkg::OFS_CTRL + 12'(l)) begin
            ctrl[l] <= REG_WDATA[5:0];
          end
          if (lower && LEVEL == 4'(l)) begin
            ctrl[l][ptpc_pkg::C_RING_LO +: 2] <= page_ring;
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // status word
  // -------------------------------------------------------------
  // a mode change applies to accesses taken after the writing edge
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      table_mode_flag <= 1'b0;
      ext_mode        <= 1'b0;
    end else if (REG_WR && REG_ADDR == ptpc_pkg::OFS_STATUS) begin
      table_mode_flag <= REG_WDATA[ptpc_pkg::ST_TMODE];
      ext_mode        <= REG_WDATA[ptpc_pkg::ST_EXT];
    end
  end

  // -------------------------------------------------------------
  // register port: entry writes go straight to the table
  // -------------------------------------------------------------
  // the port never stalls: a write lands at its own edge
  assign tif.sw_idx   = REG_ADDR[7:0];
  assign tif.sw_wdata = REG_WDATA;
  assign tif.sw_we    = REG_WR && in_entry_win(REG_ADDR);

  // read data stand one cycle, zero otherwise and for unmapped addresses;
  // zero between reads keeps stale table contents off the port
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      if (in_entry_win(REG_ADDR)) begin
        REG_RDATA <= tif.sw_rdata;
      end else if (REG_ADDR[11:4] == ptpc_pkg::OFS_CTRL[11:4]) begin
        REG_RDATA <= {26'h0, ctrl[REG_ADDR[3:0]]};
      end else if (REG_ADDR == ptpc_pkg::OFS_STATUS) begin
        REG_RDATA <= {30'h0, ext_mode, table_mode_flag};
      end else if (REG_ADDR == ptpc_pkg::OFS_FAULT) begin
        REG_RDATA <= {12'h0, fault_code, fault_vaddr};
      end else begin
        REG_RDATA <= 32'h0000_0000;
      end
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire
